// file: rtl/arc_pkg.sv
// arc_pkg: register map, field positions, reset values and conversion timing
// of the converter control block.
// assumes: one 32-bit APB slave, one bus clock, word-aligned registers.
package arc_pkg;

	// register byte offsets
	localparam logic [7:0] ARC_OFF_STATUS_CONTROL = 8'h00;
	localparam logic [7:0] ARC_OFF_CONVERTER_CTRL = 8'h04;
	localparam logic [7:0] ARC_OFF_PIN_ENABLE     = 8'h08;
	localparam logic [7:0] ARC_OFF_RESULT_HIGH    = 8'h0C;
	localparam logic [7:0] ARC_OFF_RESULT_LOW     = 8'h10;
	localparam logic [7:0] ARC_OFF_EVT_STATUS     = 8'h14;
	localparam logic [7:0] ARC_OFF_EVT_ENABLE     = 8'h18;

	// status_control_reg fields
	localparam int ARC_SC_DONE_BIT   = 7;
	localparam int ARC_SC_IRQEN_BIT  = 6;
	localparam int ARC_SC_CHAN_LSB   = 0;
	localparam int ARC_CHAN_W        = 3;

	// converter_control_reg fields
	localparam int ARC_C_PWR_BIT     = 7;
	localparam int ARC_C_DJM_BIT     = 6;
	localparam int ARC_C_RES8_BIT    = 5;
	localparam int ARC_C_SGN_BIT     = 4;
	localparam int ARC_C_PRS_LSB     = 0;
	localparam int ARC_PRS_W         = 4;

	// event status / enable fields
	localparam int ARC_EVT_DONE_BIT  = 0;
	localparam int ARC_EVT_ABORT_BIT = 1;
	localparam int ARC_EVT_W         = 2;

	// reset values
	localparam logic [7:0]           ARC_RST_SC  = 8'h00;
	localparam logic [7:0]           ARC_RST_C   = 8'h00;
	localparam logic [7:0]           ARC_RST_PE  = 8'h00;
	localparam logic [7:0]           ARC_RST_RES = 8'h00;
	localparam logic [ARC_EVT_W-1:0] ARC_RST_EVT = 2'h0;

	// conversion timing, in conversion clock cycles
	localparam int ARC_SAMPLE_TICKS  = 14;
	localparam int ARC_RES_BITS      = 10;

	// conversion sequencer states
	typedef enum logic [1:0]
	{
		ARC_IDLE   = 2'b00,
		ARC_SAMPLE = 2'b01,
		ARC_APPROX = 2'b10
	} arc_state_t;

endpackage : arc_pkg

// file: rtl/arc_prescaler.sv
// arc_prescaler: makes the conversion clock as a one-cycle tick of the bus clock.
// assumes: run is low while no conversion is active; divide factor is (prs+1)*2.
module arc_prescaler #(
	parameter int PRS_W = 4
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             srst,
	// control
	input  wire logic             run,
	input  wire logic [PRS_W-1:0] prs,
	// conversion clock tick
	output logic                  tick
);
	localparam int CNT_W = PRS_W + 1;

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] last;

	// terminal count of one conversion clock period
	assign last = {prs, 1'b1};
	assign tick = run && (cnt_r == last);

	// divider restarts whenever the sequencer is idle
	always_ff @(posedge clock)
	begin
		if (srst || !run || tick)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + CNT_W'(1);
	end

endmodule : arc_prescaler

// file: rtl/arc_converter_ctrl.sv
// arc_converter_ctrl: register file, conversion sequencer and completion interrupt
// of a successive-approximation converter.
// assumes: APB master on the bus clock; analog comparator and sample switch outside;
// comparator output is asynchronous and is synchronised here.
//
// Behaviour
// R1: system reset restores all registers and powers the converter down.
// R2: power-on bit resets cleared; converter stays disabled until software sets it.
// R3: reset ends any conversion, clears done flag and the approximation register.
// R4: reset cancels any pending completion interrupt.
// R5: setting power-on does not reinitialise register contents.
// R6: control register write stops a conversion, starts none, keeps other state.
// R7: with interrupt enabled, request rises at conversion end with results loaded.
// R8: with interrupt disabled, software polls the done flag.
// R9: request stays high while done flag and interrupt enable are both set.
// R10: any status and control register write clears the done flag.
// R11: reading either result byte clears the done flag.
// R12: seven software registers control the converter.
// R13: status and control write starts a conversion, aborting any running one.
// R14: pin enable write aborts any conversion and starts none.
// R15: sampling lasts exactly 14 conversion clock cycles before approximation.
// R16: clearing power-on aborts any conversion and enters low power.
// R17: done flag sets in the cycle the result bytes are loaded.
//
// The placing of the registers and register access over APB are this design's own decisions.
module arc_converter_ctrl
	import arc_pkg::*;
#(
	parameter int SAMPLE_TICKS = arc_pkg::ARC_SAMPLE_TICKS
) (
	// clock and reset
	input  wire logic                           clock,
	input  wire logic                           srst,
	// apb slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	input  wire logic [3:0]                     pstrb,
	output logic                                pready,
	output logic [31:0]                         prdata,
	output logic                                pslverr,
	// analog front end
	input  wire logic                           cmp_above,
	output logic                                sample_en,
	output logic [arc_pkg::ARC_RES_BITS-1:0]    sar_dac,
	output logic [arc_pkg::ARC_CHAN_W-1:0]      channel_sel,
	output logic [7:0]                          pin_enable,
	output logic                                converter_power_on,
	// interrupt
	output logic                                irq
);
	import arc_pkg::*;

	localparam int TCNT_W = $clog2(SAMPLE_TICKS + 1);
	localparam int IDX_W  = $clog2(ARC_RES_BITS);

	// register storage
	logic [7:0]           status_control_reg_r;
	logic [7:0]           converter_control_reg_r;
	logic [7:0]           input_pin_enable_reg_r;
	logic [7:0]           result_high_byte_r;
	logic [7:0]           result_low_byte_r;
	logic                 conversion_done_flag_r;
	logic [ARC_EVT_W-1:0] evt_status_r;
	logic [ARC_EVT_W-1:0] evt_enable_r;
	logic [31:0]          prdata_r;

	// sequencer
	arc_state_t              state_r;
	arc_state_t              state_nxt;
	logic [TCNT_W-1:0]       tick_cnt_r;
	logic [IDX_W-1:0]        bit_idx_r;
	logic [ARC_RES_BITS-1:0] sar_r;

	// comparator synchroniser
	logic cmp_meta_r;
	logic cmp_sync_r;

	// decoded strobes
	logic setup;
	logic access;
	logic wr_sc;
	logic wr_c;
	logic wr_pe;
	logic wr_evt_st;
	logic wr_evt_en;
	logic rd_result;
	logic mapped;
	logic tick;
	logic running;
	logic finish;
	logic abort;
	logic start;
	logic presc_run;
	logic completion_irq_enable;
	logic [7:0] wbyte;

	// true when an address hits one of the seven registers
	function automatic logic arc_hit(input logic [7:0] a);
		case (a)
			ARC_OFF_STATUS_CONTROL, ARC_OFF_CONVERTER_CTRL, ARC_OFF_PIN_ENABLE,
			ARC_OFF_RESULT_HIGH, ARC_OFF_RESULT_LOW, ARC_OFF_EVT_STATUS,
			ARC_OFF_EVT_ENABLE: arc_hit = 1'b1;
			default:            arc_hit = 1'b0;
		endcase
	endfunction : arc_hit

	// result byte layout from resolution, justification and sign selects
	function automatic logic [15:0] arc_format(input logic [ARC_RES_BITS-1:0] v,
		input logic res8, input logic djm, input logic sgn);
		logic [ARC_RES_BITS-1:0] s;
		s = v;
		if (sgn && !djm)
			s[ARC_RES_BITS-1] = ~v[ARC_RES_BITS-1];
		if (res8)
			arc_format = {s[9:2], 8'h00};
		else if (djm)
			arc_format = {6'h00, v[9:8], v[7:0]};
		else
			arc_format = {s[9:2], s[1:0], 6'h00};
	endfunction : arc_format

	// apb decode: registers answer with no wait state
	assign setup     = psel && !penable;
	assign access    = psel && penable;
	assign mapped    = arc_hit(paddr); // R12
	assign wbyte     = pstrb[0] ? pwdata[7:0] : 8'h00;
	assign wr_sc     = access && pwrite && pstrb[0] && (paddr == ARC_OFF_STATUS_CONTROL);
	assign wr_c      = access && pwrite && pstrb[0] && (paddr == ARC_OFF_CONVERTER_CTRL);
	assign wr_pe     = access && pwrite && pstrb[0] && (paddr == ARC_OFF_PIN_ENABLE);
	assign wr_evt_st = access && pwrite && pstrb[0] && (paddr == ARC_OFF_EVT_STATUS);
	assign wr_evt_en = access && pwrite && pstrb[0] && (paddr == ARC_OFF_EVT_ENABLE);
	assign rd_result = access && !pwrite &&
		((paddr == ARC_OFF_RESULT_HIGH) || (paddr == ARC_OFF_RESULT_LOW));
	assign pready    = 1'b1;
	assign pslverr   = access && !mapped;
	assign prdata    = prdata_r;

	// read data captured in the setup cycle
	always_ff @(posedge clock)
	begin
		if (srst)
			prdata_r <= 32'h0000_0000;
		else if (setup && !pwrite)
		begin
			case (paddr)
				ARC_OFF_STATUS_CONTROL:
					prdata_r <= {24'h00_0000, conversion_done_flag_r, status_control_reg_r[6:0]};
				ARC_OFF_CONVERTER_CTRL: prdata_r <= {24'h00_0000, converter_control_reg_r};
				ARC_OFF_PIN_ENABLE:     prdata_r <= {24'h00_0000, input_pin_enable_reg_r};
				ARC_OFF_RESULT_HIGH:    prdata_r <= {24'h00_0000, result_high_byte_r};
				ARC_OFF_RESULT_LOW:     prdata_r <= {24'h00_0000, result_low_byte_r};
				ARC_OFF_EVT_STATUS:     prdata_r <= {24'h00_0000, {(8-ARC_EVT_W){1'b0}}, evt_status_r};
				ARC_OFF_EVT_ENABLE:     prdata_r <= {24'h00_0000, {(8-ARC_EVT_W){1'b0}}, evt_enable_r};
				default:                prdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// status and control register; only reset restores it, never power-on
	always_ff @(posedge clock)
	begin
		if (srst)
			status_control_reg_r <= ARC_RST_SC; // R1
		else if (wr_sc)
			status_control_reg_r <= {1'b0, wbyte[6:0]}; // R5
	end

	// control register holds power-on, format and prescaler selects
	always_ff @(posedge clock)
	begin
		if (srst)
			converter_control_reg_r <= ARC_RST_C; // R2
		else if (wr_c)
			converter_control_reg_r <= wbyte;
	end

	// pin enable register
	always_ff @(posedge clock)
	begin
		if (srst)
			input_pin_enable_reg_r <= ARC_RST_PE; // R1
		else if (wr_pe)
			input_pin_enable_reg_r <= wbyte;
	end

	// event enable register
	always_ff @(posedge clock)
	begin
		if (srst)
			evt_enable_r <= ARC_RST_EVT; // R1
		else if (wr_evt_en)
			evt_enable_r <= wbyte[ARC_EVT_W-1:0];
	end

	assign converter_power_on    = converter_control_reg_r[ARC_C_PWR_BIT];
	assign completion_irq_enable = status_control_reg_r[ARC_SC_IRQEN_BIT];
	assign channel_sel           = status_control_reg_r[ARC_SC_CHAN_LSB +: ARC_CHAN_W];
	assign pin_enable            = input_pin_enable_reg_r;

	// start and abort causes
	assign running = (state_r != ARC_IDLE);
	assign start   = wr_sc && converter_power_on; // R13
	assign abort   = running && (wr_c || wr_pe || wr_sc || !converter_power_on); // R6 R14 R16
	assign finish  = (state_r == ARC_APPROX) && tick && (bit_idx_r == '0) && !abort;

	// divider restarts on every start, else a restart gets a short first tick
	assign presc_run = running && !start; // R13 R15

	// conversion clock
	arc_prescaler #(
		.PRS_W (ARC_PRS_W)
	) u_prescaler (
		.clock (clock),
		.srst  (srst),
		.run   (presc_run),
		.prs   (converter_control_reg_r[ARC_C_PRS_LSB +: ARC_PRS_W]),
		.tick  (tick)
	);

	// comparator pin passes two flip-flops
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
		end
		else
		begin
			cmp_meta_r <= cmp_above;
			cmp_sync_r <= cmp_meta_r;
		end
	end

	// sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ARC_IDLE:
				if (start)
					state_nxt = ARC_SAMPLE;
			ARC_SAMPLE:
				if (start)
					state_nxt = ARC_SAMPLE; // R13
				else if (abort)
					state_nxt = ARC_IDLE;
				else if (tick && (tick_cnt_r == TCNT_W'(SAMPLE_TICKS - 1)))
					state_nxt = ARC_APPROX; // R15
			ARC_APPROX:
				if (start)
					state_nxt = ARC_SAMPLE;
				else if (abort || finish)
					state_nxt = ARC_IDLE;
			default:
				state_nxt = ARC_IDLE;
		endcase
	end

	// sequencer state; reset terminates any conversion
	always_ff @(posedge clock)
	begin
		if (srst)
			state_r <= ARC_IDLE; // R3
		else
			state_r <= state_nxt;
	end

	// sampling window counter
	always_ff @(posedge clock)
	begin
		if (srst || state_nxt != ARC_SAMPLE || start)
			tick_cnt_r <= '0;
		else if (tick)
			tick_cnt_r <= tick_cnt_r + TCNT_W'(1); // R15
	end

	// successive approximation: trial bit kept when the input stays above the dac
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sar_r     <= '0; // R3
			bit_idx_r <= '0;
		end
		else if (state_r == ARC_SAMPLE && state_nxt == ARC_APPROX)
		begin
			sar_r     <= {1'b1, {(ARC_RES_BITS-1){1'b0}}};
			bit_idx_r <= IDX_W'(ARC_RES_BITS - 1);
		end
		else if (state_nxt == ARC_IDLE && state_r != ARC_APPROX)
		begin
			sar_r     <= sar_r;
			bit_idx_r <= '0;
		end
		else if (state_r == ARC_APPROX && tick && !abort && !start)
		begin
			sar_r[bit_idx_r] <= cmp_sync_r;
			if (bit_idx_r != '0)
			begin
				sar_r[bit_idx_r - IDX_W'(1)] <= 1'b1;
				bit_idx_r                    <= bit_idx_r - IDX_W'(1);
			end
		end
	end

	// analog drive: switch closed only while sampling
	assign sample_en = (state_r == ARC_SAMPLE) && converter_power_on;
	assign sar_dac   = sar_r;

	// result bytes loaded from the final trial
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			result_high_byte_r <= ARC_RST_RES; // R1
			result_low_byte_r  <= ARC_RST_RES;
		end
		else if (finish)
		begin
			{result_high_byte_r, result_low_byte_r} <= arc_format(
				{sar_r[ARC_RES_BITS-1:1], cmp_sync_r},
				converter_control_reg_r[ARC_C_RES8_BIT],
				converter_control_reg_r[ARC_C_DJM_BIT],
				converter_control_reg_r[ARC_C_SGN_BIT]); // R7
		end
	end

	// done flag: completion wins over a same-cycle clear
	always_ff @(posedge clock)
	begin
		if (srst)
			conversion_done_flag_r <= 1'b0; // R3
		else if (finish)
			conversion_done_flag_r <= 1'b1; // R17
		else if (wr_sc || rd_result)
			conversion_done_flag_r <= 1'b0; // R10 R11
	end

	// sticky events, write one to clear, set wins over clear
	always_ff @(posedge clock)
	begin
		if (srst)
			evt_status_r <= ARC_RST_EVT; // R4
		else
		begin
			if (finish)
				evt_status_r[ARC_EVT_DONE_BIT] <= 1'b1;
			else if (wr_evt_st && wbyte[ARC_EVT_DONE_BIT])
				evt_status_r[ARC_EVT_DONE_BIT] <= 1'b0;
			if (abort)
				evt_status_r[ARC_EVT_ABORT_BIT] <= 1'b1;
			else if (wr_evt_st && wbyte[ARC_EVT_ABORT_BIT])
				evt_status_r[ARC_EVT_ABORT_BIT] <= 1'b0;
		end
	end

	// level interrupt; polling path needs no enable
	assign irq = (conversion_done_flag_r && completion_irq_enable) || // R7 R9 R8
		(|(evt_status_r & evt_enable_r));

endmodule : arc_converter_ctrl

// file: tb/arc_converter_ctrl_props.sv
// arc_converter_ctrl_props: port assertions of the converter control block.
// assumes: bound into arc_converter_ctrl, one clock, synchronous reset.
module arc_converter_ctrl_props
	import arc_pkg::*;
#(
	parameter int SAMPLE_TICKS = 14
) (
	// clock and reset
	input wire logic                    clock,
	input wire logic                    srst,
	// apb
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [7:0]              paddr,
	input wire logic [31:0]             pwdata,
	input wire logic [3:0]              pstrb,
	input wire logic                    pslverr,
	// converter
	input wire logic                    sample_en,
	input wire logic [ARC_RES_BITS-1:0] sar_dac,
	input wire logic                    converter_power_on,
	input wire logic                    irq
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);

	// bus decode
	logic       wr;
	logic       rr;
	logic       ev_r;
	logic       ie_r;
	logic [3:0] prs_r;
	int         scnt_r;
	int         f;
	assign wr = psel && penable && pwrite && pstrb[0];
	assign rr = psel && penable && !pwrite && (paddr == ARC_OFF_RESULT_HIGH || paddr == ARC_OFF_RESULT_LOW);
	assign f = (int'(prs_r) + 1) * 2;

	// mirror of written settings
	always_ff @(posedge clock)
		if (srst)
		begin
			ev_r <= 1'b0;
			ie_r <= 1'b0;
			prs_r <= 4'h0;
		end
		else if (wr)
		begin
			if (paddr == ARC_OFF_EVT_ENABLE)
				ev_r <= |pwdata[1:0];
			if (paddr == ARC_OFF_STATUS_CONTROL)
				ie_r <= pwdata[6];
			if (paddr == ARC_OFF_CONVERTER_CTRL)
				prs_r <= pwdata[3:0];
		end

	// length of the current sampling window
	always_ff @(posedge clock)
		if (srst || wr || !sample_en)
			scnt_r <= 0;
		else
			scnt_r <= scnt_r + 1;

	rst_state_a:
		assert property (disable iff (1'b0) srst |=> !sample_en && !converter_power_on && sar_dac == '0)
		else $error("state not cleared by reset");
	rst_irq_a:
		assert property (disable iff (1'b0) srst |=> !irq)
		else $error("irq pending after reset");
	samp_len_a:
		assert property ($fell(sample_en) && !$past(wr) |-> scnt_r > (SAMPLE_TICKS - 1) * f
			&& scnt_r <= SAMPLE_TICKS * f + 1)
		else $error("sampling window wrong length");
	samp_pwr_a:
		assert property (!converter_power_on |=> !sample_en && $stable(sar_dac))
		else $error("sequencer active while powered down");
	sc_start_a:
		assert property (wr && paddr == ARC_OFF_STATUS_CONTROL && converter_power_on |=> sample_en)
		else $error("status write did not start");
	stop_nostart_a:
		assert property (wr && (paddr == ARC_OFF_CONVERTER_CTRL || paddr == ARC_OFF_PIN_ENABLE) |=> !sample_en)
		else $error("control write did not stop");
	sc_clear_a:
		assert property (wr && paddr == ARC_OFF_STATUS_CONTROL && !ev_r |=> !irq)
		else $error("status write left irq up");
	res_clear_a:
		assert property (rr && !ev_r |=> !irq)
		else $error("result read left irq up");
	irq_cause_a:
		assert property ($rose(irq) && !ev_r |-> ie_r && !sample_en)
		else $error("irq without enable");
	slverr_acc_a:
		assert property (pslverr |-> psel && penable)
		else $error("error outside access");

	c_irq: cover property ($rose(irq));
	c_samp: cover property ($fell(sample_en) && !$past(wr));
	c_err: cover property (pslverr);
endmodule : arc_converter_ctrl_props

bind arc_converter_ctrl arc_converter_ctrl_props #(.SAMPLE_TICKS(SAMPLE_TICKS)) props_u (.clock(clock),
	.srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pslverr(pslverr), .sample_en(sample_en), .sar_dac(sar_dac),
	.converter_power_on(converter_power_on), .irq(irq));

// file: tb/adc_reset_and_completion_irq_bench.sv
// adc_reset_and_completion_irq_bench: directed apb tests of the converter control block.
// assumes: package, design and checker compiled first; comparator driven here.
module adc_reset_and_completion_irq_bench
	import arc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// stimulus and observed ports
	logic        clock = 0;
	logic        srst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic        cmp_above = 1;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, sample_en, converter_power_on, irq, e;
	logic [31:0] prdata, q;
	logic [9:0]  sar_dac;
	logic [2:0]  channel_sel;
	logic [7:0]  pin_enable;
	int          num_errors = 0;
	int          n_checks = 0;
	int          k;

	arc_converter_ctrl dut_u (.clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.cmp_above(cmp_above), .sample_en(sample_en), .sar_dac(sar_dac), .channel_sel(channel_sel),
		.pin_enable(pin_enable), .converter_power_on(converter_power_on), .irq(irq));

	// 25 ns clock and hang guard
	initial
		forever #12.5 clock = ~clock;
	initial
	begin
		#2ms;
		give_up();
	end

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	task automatic give_up();
		num_errors++;
		$display("BAD %0t wait limit reached", $time);
		test_done();
	endtask : give_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one apb transfer: setup, then access until pready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		pstrb <= s;
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (n >= 16)
			give_up();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] a, input logic [7:0] ex);
		xfer(1'b0, a, 8'h00);
		chk(q, 32'(ex));
	endtask : rd

	task automatic wait_irq();
		k = 0;
		while (irq !== 1'b1 && k < 400)
		begin
			@(negedge clock);
			k++;
		end
		if (k >= 400)
			give_up();
	endtask : wait_irq

	task automatic pulse_rst();
		@(posedge clock);
		srst <= 1'b1;
		@(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk(32'(irq), 0);
		chk(32'(sample_en), 0);
		chk(32'(sar_dac), 0);
		chk(32'(converter_power_on), 0);
		rd(ARC_OFF_STATUS_CONTROL, 8'h00);
	endtask : pulse_rst

	// main sequence
	initial
	begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rd(8'(4 * i), 8'h00);
		xfer(1'b0, 8'h1c, 8'h00);
		chk(32'(e), 1);
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80, 4'he);
		rd(ARC_OFF_CONVERTER_CTRL, 8'h00);
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80);
		rd(ARC_OFF_CONVERTER_CTRL, 8'h80);
		rd(ARC_OFF_STATUS_CONTROL, 8'h00);
		// full-scale conversion with interrupt, restarted during sampling
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		@(negedge clock);
		k = 0;
		while (sample_en === 1'b1 && k < 100)
		begin
			@(negedge clock);
			k++;
		end
		chk(k, 2 * ARC_SAMPLE_TICKS);
		wait_irq();
		rd(ARC_OFF_STATUS_CONTROL, 8'hc0);
		chk(32'(irq), 1);
		rd(ARC_OFF_RESULT_HIGH, 8'hff);
		@(negedge clock);
		chk(32'(irq), 0);
		rd(ARC_OFF_RESULT_LOW, 8'hc0);
		// restart, then abort by control write
		@(posedge clock);
		cmp_above <= 1'b0;
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h45);
		wait_irq();
		chk(32'(channel_sel), 5);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h45);
		@(negedge clock);
		chk(32'(irq), 0);
		chk(32'(sample_en), 1);
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80);
		@(negedge clock);
		chk(32'(sample_en), 0);
		repeat (100) @(negedge clock);
		chk(32'(irq), 0);
		rd(ARC_OFF_STATUS_CONTROL, 8'h45);
		// pin enable abort, then polled conversion
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h00);
		xfer(1'b1, ARC_OFF_PIN_ENABLE, 8'h01);
		@(negedge clock);
		chk(32'(sample_en), 0);
		chk(32'(pin_enable), 1);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h00);
		q = 32'h0000_0000;
		for (int i = 0; i < 100 && q[7] !== 1'b1; i++)
			xfer(1'b0, ARC_OFF_STATUS_CONTROL, 8'h00);
		chk(q, 32'h0000_0080);
		@(negedge clock);
		chk(32'(irq), 0);
		// abort event: raise, mask, clear
		xfer(1'b1, ARC_OFF_EVT_STATUS, 8'h03);
		xfer(1'b1, ARC_OFF_EVT_ENABLE, 8'h02);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h00);
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80);
		@(negedge clock);
		chk(32'(irq), 1);
		rd(ARC_OFF_EVT_STATUS, 8'h02);
		xfer(1'b1, ARC_OFF_EVT_ENABLE, 8'h00);
		@(negedge clock);
		chk(32'(irq), 0);
		xfer(1'b1, ARC_OFF_EVT_ENABLE, 8'h02);
		xfer(1'b1, ARC_OFF_EVT_STATUS, 8'h02);
		@(negedge clock);
		chk(32'(irq), 0);
		xfer(1'b1, ARC_OFF_EVT_ENABLE, 8'h00);
		// power down aborts and blocks starts
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h00);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		@(negedge clock);
		chk(32'(sample_en), 0);
		// reset with interrupt pending, then mid-conversion
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		wait_irq();
		pulse_rst();
		xfer(1'b1, ARC_OFF_CONVERTER_CTRL, 8'h80);
		xfer(1'b1, ARC_OFF_STATUS_CONTROL, 8'h40);
		repeat (36) @(negedge clock);
		pulse_rst();
		test_done();
	end
endmodule : adc_reset_and_completion_irq_bench
